// [rtl/cmd_decoder_params.svh]
`ifndef CMD_DECODER_PARAMS_SVH
`define CMD_DECODER_PARAMS_SVH

// Command byte field layout
`define CMD_FLAG_BIT 7
`define CMD_TYPE_MSB 6
`define CMD_TYPE_LSB 5
`define CMD_ADD_MSB 4
`define CMD_ADD_LSB 0

// Transfer type codes
`define TYPE_REPEAT 2'h0
`define TYPE_AUTO 2'h1
`define TYPE_RESERVED 2'h2
`define TYPE_SPECIAL 2'h3

// Special function codes
`define SF_NOP 5'h00
`define SF_INT_CLEAR 5'h06

// Reset values
`define PTR_RESET 5'h00
`define CMD_RESET 8'h00

`endif

// [rtl/cmd_decoder_pkg.sv]
package cmd_decoder_pkg;

  // Byte events from the serial front end, same clock domain
  typedef struct packed {
    logic wr_valid;
    logic first_byte;
    logic [7:0] wr_byte;
    logic rd_done;
  } bus_event_t;

  // Register write request toward the register bank
  typedef struct packed {
    logic stb;
    logic [4:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic [4:0] ptr;
    logic auto_inc;
    logic [7:0] cmd;
    reg_write_t wr;
    logic int_clr;
    logic int_pend;
  } decoder_state_t;

endpackage

// [rtl/serial_command_pointer_decoder.sv]
`timescale 1ns/100ps
`include "cmd_decoder_params.svh"
// What this block does
// - Keep register target from latest repeat or auto-increment command byte for all later transfers.
// - Bits 6:5 pick repeat, auto-increment or special; 10 is reserved.
// - Repeat type returns the same register on every read byte.
// - Auto-increment type advances the pointer by one after each data byte.
// - Bits 4:0 are function code for special type, else register address.
// - Special code 00000 does nothing; only 00000 and 00110 are allowed.
// - Code 00110 clears the pending light interrupt and drops its indication.
// - Interrupt clear is a one-shot action leaving no state behind.
// - First byte after bus address is the command byte if bit 7 is set; other bytes are data.
// - Write byte with bit 7 clear is data at the held address.
// - Read without new command uses the address from the previous command.
// - Raised light interrupt stays asserted until the clear function arrives.
module serial_command_pointer_decoder (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire cmd_decoder_pkg::bus_event_t bus_ev,
  input wire logic threshold_hit,
  output logic [4:0] reg_pointer,
  output logic [7:0] stored_cmd,
  output cmd_decoder_pkg::reg_write_t reg_wr,
  output logic int_clear,
  output logic light_int
);

  cmd_decoder_pkg::decoder_state_t st;
  cmd_decoder_pkg::decoder_state_t next_st;
  logic cmd_take;
  logic data_take;
  logic [1:0] cmd_type;
  logic [4:0] cmd_add;
  logic clr_take;

  function automatic logic [4:0] advance(input logic [4:0] ptr, input logic inc);
    advance = inc ? 5'(ptr + 5'h01) : ptr;
  endfunction

  assign cmd_take = bus_ev.wr_valid && bus_ev.first_byte && bus_ev.wr_byte[`CMD_FLAG_BIT];
  assign data_take = bus_ev.wr_valid && !cmd_take;
  assign cmd_type = bus_ev.wr_byte[`CMD_TYPE_MSB:`CMD_TYPE_LSB];
  assign cmd_add = bus_ev.wr_byte[`CMD_ADD_MSB:`CMD_ADD_LSB];
  assign clr_take = cmd_take && cmd_type == `TYPE_SPECIAL && cmd_add == `SF_INT_CLEAR;

  always_comb begin
    next_st = st;
    next_st.wr.stb = 1'b0;
    next_st.int_clr = 1'b0;
    if (cmd_take) begin
      next_st.cmd = bus_ev.wr_byte;
      case (cmd_type)
        `TYPE_REPEAT, `TYPE_AUTO: begin
          next_st.ptr = cmd_add;
          next_st.auto_inc = (cmd_type == `TYPE_AUTO);
        end
        `TYPE_SPECIAL: begin
          // Code in ADD field; pointer and type left alone
          if (cmd_add == `SF_INT_CLEAR) begin
            next_st.int_clr = 1'b1;
          end
        end
        default: begin
          next_st.int_clr = 1'b0;
        end
      endcase
    end else if (data_take) begin
      next_st.wr.stb = 1'b1;
      next_st.wr.addr = st.ptr;
      next_st.wr.data = bus_ev.wr_byte;
      next_st.ptr = advance(st.ptr, st.auto_inc);
    end else if (bus_ev.rd_done) begin
      next_st.ptr = advance(st.ptr, st.auto_inc);
    end
    // Clear first, so a threshold hit in the same cycle is not lost
    if (next_st.int_clr) begin
      next_st.int_pend = 1'b0;
    end
    if (threshold_hit) begin
      next_st.int_pend = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '0;
      st.ptr <= `PTR_RESET;
      st.cmd <= `CMD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign reg_pointer = st.ptr;
  assign stored_cmd = st.cmd;
  assign reg_wr = st.wr;
  assign int_clear = st.int_clr;
  assign light_int = st.int_pend;

  a_ptr_load_cmd: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take && (cmd_type == `TYPE_REPEAT || cmd_type == `TYPE_AUTO)
    |=> reg_pointer == $past(cmd_add) && stored_cmd == $past(bus_ev.wr_byte))
    else $error("pointer not loaded from command byte");

  a_ptr_repeat_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus_ev.rd_done || data_take) && !cmd_take && !st.auto_inc |=> $stable(reg_pointer))
    else $error("pointer moved in repeated byte mode");

  a_ptr_auto_step: assert property (@(posedge mclk) disable iff (sys_rst)
    (bus_ev.rd_done || data_take) && !cmd_take && st.auto_inc
    |=> reg_pointer == 5'($past(reg_pointer) + 5'h01))
    else $error("pointer did not advance by one");

  a_wr_at_ptr: assert property (@(posedge mclk) disable iff (sys_rst)
    data_take |=> reg_wr.stb && reg_wr.addr == $past(reg_pointer) && reg_wr.data == $past(bus_ev.wr_byte))
    else $error("data write not at held address");

  a_no_stray_wr: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr.stb |-> $past(bus_ev.wr_valid) && !$past(cmd_take))
    else $error("write strobe without data byte");

  a_clr_cause: assert property (@(posedge mclk) disable iff (sys_rst)
    int_clear |-> $past(cmd_take) && $past(bus_ev.wr_byte) == {1'b1, `TYPE_SPECIAL, `SF_INT_CLEAR})
    else $error("interrupt clear without clear command");

  a_clr_one_shot: assert property (@(posedge mclk) disable iff (sys_rst)
    int_clear && !clr_take |=> !int_clear)
    else $error("interrupt clear held");

  a_clr_drops_int: assert property (@(posedge mclk) disable iff (sys_rst)
    int_clear && !$past(threshold_hit) |-> !light_int)
    else $error("interrupt still pending after clear");

  a_int_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(light_int) |-> int_clear)
    else $error("interrupt dropped without clear");

  a_reserved_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take && (cmd_type == `TYPE_RESERVED || (cmd_type == `TYPE_SPECIAL && cmd_add != `SF_INT_CLEAR))
    |=> !int_clear && $stable(reg_pointer) && !reg_wr.stb)
    else $error("reserved or no-op command had an effect");

  // Reset leaves an idle pointer in repeat mode with no strobes
  a_reset_idle: assert property (@(posedge mclk)
    sys_rst |=> reg_pointer == `PTR_RESET && stored_cmd == `CMD_RESET && !st.auto_inc
      && !reg_wr.stb && !int_clear && !light_int)
    else $error("state not idle after reset");

  // Command byte handling
  a_cmd_store: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take |=> stored_cmd == $past(bus_ev.wr_byte))
    else $error("command byte not stored");

  a_cmd_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    !cmd_take |=> $stable(stored_cmd))
    else $error("stored command changed without command byte");

  a_mode_select: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take && (cmd_type == `TYPE_REPEAT || cmd_type == `TYPE_AUTO)
    |=> st.auto_inc == ($past(cmd_type) == `TYPE_AUTO))
    else $error("transfer type not taken from command");

  a_special_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take && cmd_type == `TYPE_SPECIAL |=> $stable(reg_pointer) && $stable(st.auto_inc))
    else $error("special function moved the pointer");

  a_reserved_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take && cmd_type == `TYPE_RESERVED |=> $stable(st.auto_inc) && !int_clear)
    else $error("reserved type changed the mode");

  a_cmd_no_wr: assert property (@(posedge mclk) disable iff (sys_rst)
    cmd_take |=> !reg_wr.stb)
    else $error("command byte written as data");

  // Data bytes and read bytes
  a_clear_msb_data: assert property (@(posedge mclk) disable iff (sys_rst)
    bus_ev.wr_valid && !bus_ev.wr_byte[`CMD_FLAG_BIT] |=> reg_wr.stb)
    else $error("byte with flag clear not written");

  a_later_byte_data: assert property (@(posedge mclk) disable iff (sys_rst)
    bus_ev.wr_valid && !bus_ev.first_byte |=> reg_wr.stb && !int_clear)
    else $error("later byte not treated as data");

  a_rd_wr_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    bus_ev.rd_done && data_take |=> reg_wr.stb && reg_wr.addr == $past(reg_pointer))
    else $error("read event displaced a data write");

  a_stb_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr.stb && !data_take |=> !reg_wr.stb)
    else $error("write strobe held");

  a_rd_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    bus_ev.rd_done && !bus_ev.wr_valid |=> !reg_wr.stb && !int_clear && $stable(stored_cmd))
    else $error("read byte caused a write or command");

  a_idle_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !bus_ev.wr_valid && !bus_ev.rd_done
    |=> $stable(reg_pointer) && !reg_wr.stb && !int_clear)
    else $error("pointer or strobe moved while bus idle");

  a_wr_fields_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !data_take |=> $stable(reg_wr.addr) && $stable(reg_wr.data))
    else $error("write target changed without data byte");

  a_auto_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
    data_take && st.auto_inc && reg_pointer == 5'h1F |=> reg_pointer == 5'h00)
    else $error("pointer did not wrap to zero");

  // Interrupt flag: set wins over a clear in the same cycle
  a_int_set_hit: assert property (@(posedge mclk) disable iff (sys_rst)
    threshold_hit |=> light_int)
    else $error("threshold hit did not raise interrupt");

  a_int_rise_cause: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(light_int) |-> $past(threshold_hit))
    else $error("interrupt raised without threshold hit");

  a_int_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    light_int && !clr_take |=> light_int)
    else $error("interrupt released without clear command");

endmodule

// [test/host_model.sv]
`timescale 1ns/100ps
module host_model (
  input wire logic mclk,
  output cmd_decoder_pkg::bus_event_t bus_ev
);
  initial bus_ev = '0;
  // One byte event per call; the released byte shows inverted so stale data never looks valid
  task automatic put(input logic first, input logic [7:0] b, input logic rd);
    @(negedge mclk);
    bus_ev <= '{wr_valid: !rd, first_byte: first, wr_byte: b, rd_done: rd};
    @(negedge mclk);
    bus_ev <= '{wr_valid: 1'b0, first_byte: 1'b0, wr_byte: ~b, rd_done: 1'b0};
  endtask
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
  logic mclk = 0;
  logic sys_rst = 1;
  logic threshold_hit = 0;
  cmd_decoder_pkg::bus_event_t bus_ev;
  cmd_decoder_pkg::reg_write_t reg_wr;
  logic [4:0] reg_pointer;
  logic [7:0] stored_cmd;
  logic int_clear;
  logic light_int;
  logic [14:0] exp_q[$];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'hd4d4;
  always #5 mclk = ~mclk;
  host_model host (.mclk(mclk), .bus_ev(bus_ev));
  serial_command_pointer_decoder DUT (.mclk(mclk), .sys_rst(sys_rst), .bus_ev(bus_ev),
    .threshold_hit(threshold_hit), .reg_pointer(reg_pointer), .stored_cmd(stored_cmd),
    .reg_wr(reg_wr), .int_clear(int_clear), .light_int(light_int));
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Bit 7 kept clear so a first byte is still data
  task automatic wr_data(input logic first, input logic [4:0] a);
    logic [7:0] d;
    d = 8'h7F & $random(seed);
    exp_q.push_back({2'b00, a, d});
    host.put(first, d, 1'b0);
  endtask
  task automatic finish_test;
    if (exp_q.size() != 0) begin
      fails++;
      $display("wrong value at %0t: %0d expected results never seen", $time, exp_q.size());
    end
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Sampled mid-cycle, so each one-cycle strobe is seen exactly once
  always @(negedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      finish_test;
    end else if (reg_wr.stb === 1'b1 || int_clear === 1'b1) begin
      chk({1'b0, int_clear, reg_wr.stb ? {reg_wr.addr, reg_wr.data} : 13'h0},
        exp_q.size() ? exp_q.pop_front() : 15'h7FFF);
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk) sys_rst <= 0;
    host.put(1'b1, 8'h85, 1'b0);
    wr_data(1'b0, 5'h05);
    wr_data(1'b0, 5'h05);
    host.put(1'b0, 8'h00, 1'b1);
    chk(15'(reg_pointer), 15'h05);
    host.put(1'b1, 8'hBE, 1'b0);
    wr_data(1'b0, 5'h1E);
    wr_data(1'b0, 5'h1F);
    wr_data(1'b0, 5'h00);
    host.put(1'b1, 8'hC3, 1'b0);
    chk(15'(stored_cmd), 15'hC3);
    wr_data(1'b0, 5'h01);
    @(negedge mclk) threshold_hit <= 1;
    @(negedge mclk) threshold_hit <= 0;
    host.put(1'b1, 8'hE0, 1'b0);
    chk(15'(light_int), 15'h1);
    exp_q.push_back(15'h2000);
    host.put(1'b1, 8'hE6, 1'b0);
    chk(15'(light_int), 15'h0);
    chk(15'(reg_pointer), 15'h02);
    @(negedge mclk);
    chk(15'(int_clear), 15'h0);
    wr_data(1'b1, 5'h02);
    host.put(1'b0, 8'h00, 1'b1);
    chk(15'(reg_pointer), 15'h04);
    repeat (3) @(negedge mclk);
    finish_test;
  end
endmodule
